// file: rtl/iabr_pkg.sv
package iabr_pkg;

    // ************************************************************
    // Register offsets and reset values.
    // ************************************************************
    localparam logic [7:0] OFS_SCRATCH = 8'h79;
    localparam logic [7:0] OFS_CONTROL = 8'hB0;
    localparam logic [7:0] OFS_OFFSET = 8'hB1;
    localparam logic [7:0] OFS_DATA = 8'hB2;
    localparam logic [7:0] OFS_SELF_TEST = 8'hB3;
    localparam logic [7:0] SCRATCH_RESET = 8'h01;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] SELF_TEST_RESET = 8'h08;
    localparam logic [7:0] OFFSET_STEP = 8'h01;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CTL_SEL_HI = 5;
    localparam int CTL_SEL_LO = 2;
    localparam int CTL_AUTOINC_BIT = 1;
    localparam int CTL_PREFETCH_BIT = 0;
    localparam int ST_MODE_HI = 7;
    localparam int ST_MODE_LO = 6;
    localparam int ST_PIN_BIT = 3;
    localparam int ST_CLK_HI = 2;
    localparam int ST_CLK_LO = 1;
    localparam int ST_EN_BIT = 0;

    // ************************************************************
    // Target codes, block slots and self-test modes.
    // ************************************************************
    localparam logic [3:0] TGT_PATTERN = 4'h0;
    localparam logic [3:0] TGT_PORT0 = 4'h1;
    localparam logic [3:0] TGT_PORT1 = 4'h2;
    localparam logic [3:0] TGT_SHARED = 4'h5;
    localparam logic [3:0] TGT_BOTH_PORTS = 4'h6;
    localparam int NUM_BLOCKS = 4;
    localparam int BLK_PATTERN = 0;
    localparam int BLK_PORT0 = 1;
    localparam int BLK_PORT1 = 2;
    localparam int BLK_SHARED = 3;
    localparam logic [1:0] MODE_STATIC = 2'h0;
    localparam logic [1:0] MODE_ALTERNATE = 2'h1;
    localparam int MODE_DATA_BIT = 1;
    localparam logic [7:0] REMOTE_CLOCK_OFFSET = 8'h14;

    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] wdata;
        logic [NUM_BLOCKS-1:0] wr;
        logic [NUM_BLOCKS-1:0] rd;
    } iabr_window_req_type;

    typedef struct packed {
        logic [7:0] offset;
        logic [1:0] clock_select;
    } iabr_remote_write_type;

    typedef enum logic {
        RW_IDLE,
        RW_BUSY
    } iabr_remote_state_type;

endpackage

// file: rtl/iabr_regs.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Scratch byte, resets 0x01, plain storage.
// - Select field picks the indirect target block.
// - Code 0110 writes both ports together.
// - Auto-increment advances offset after each access.
// - Offset write with prefetch strobes a read.
// - Prefetch plus autoinc strobes after data read.
// - Offset register addresses the selected block.
// - Data write stores byte at current offset.
// - Data read returns selected block register.
// - Output mode: static, alternating, data-driven.
// - Pin or register bits control self-test.
// - Enable sends clock select to remote 0x14.
// - Enable bit starts or stops self-test.
module iabr_regs (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output iabr_pkg::iabr_window_req_type window_req_o,
    input wire logic [iabr_pkg::NUM_BLOCKS-1:0][7:0] window_rdata_i,
    input wire logic self_test_pin_i,
    input wire logic self_test_data_i,
    output logic self_test_active_o,
    output logic self_test_out_o,
    output logic remote_req_o,
    output iabr_pkg::iabr_remote_write_type remote_payload_o,
    input wire logic remote_ack_i
);
    import iabr_pkg::*;

    logic [7:0] scratch_reg;
    logic [7:0] control_reg;
    logic [7:0] offset_reg;
    logic [7:0] self_test_reg;
    logic prefetch_reg;
    logic active_reg;
    logic toggle_reg;
    logic [3:0] window_target_select;
    logic window_offset_autoinc;
    logic window_prefetch_enable;
    logic [1:0] self_test_output_mode;
    logic self_test_pin_control;
    logic [1:0] self_test_clock_select;
    logic active_next;
    logic data_wr;
    logic data_rd;
    logic offset_wr;
    logic start_remote;

    // ************************************************************
    // Decoding shared by write and read paths.
    // ************************************************************
    function automatic logic [NUM_BLOCKS-1:0] target_mask(input logic [3:0] sel,
                                                          input logic is_write);
        logic [NUM_BLOCKS-1:0] mask;
        mask = '0;
        case (sel)
            TGT_PATTERN: mask[BLK_PATTERN] = 1'b1;
            TGT_PORT0: mask[BLK_PORT0] = 1'b1;
            TGT_PORT1: mask[BLK_PORT1] = 1'b1;
            TGT_SHARED: mask[BLK_SHARED] = 1'b1;
            TGT_BOTH_PORTS: begin
                // Broadcast only makes sense for writes; reads come from port 0.
                mask[BLK_PORT0] = 1'b1;
                mask[BLK_PORT1] = is_write;
            end
            default: mask = '0;
        endcase
        return mask;
    endfunction

    function automatic logic [7:0] window_read(input logic [3:0] sel,
                                               input logic [NUM_BLOCKS-1:0][7:0] rdata);
        logic [7:0] value;
        logic [NUM_BLOCKS-1:0] mask;
        value = READ_ZERO;
        mask = target_mask(sel, 1'b0);
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            if (mask[i]) begin
                value = rdata[i];
            end
        end
        return value;
    endfunction

    assign window_target_select = control_reg[CTL_SEL_HI:CTL_SEL_LO];
    assign window_offset_autoinc = control_reg[CTL_AUTOINC_BIT];
    assign window_prefetch_enable = control_reg[CTL_PREFETCH_BIT];
    assign self_test_output_mode = self_test_reg[ST_MODE_HI:ST_MODE_LO];
    assign self_test_pin_control = self_test_reg[ST_PIN_BIT];
    assign self_test_clock_select = self_test_reg[ST_CLK_HI:ST_CLK_LO];
    assign data_wr = reg_wr_i && reg_addr_i == OFS_DATA;
    assign data_rd = reg_rd_i && reg_addr_i == OFS_DATA;
    assign offset_wr = reg_wr_i && reg_addr_i == OFS_OFFSET;

    // ************************************************************
    // Host-visible registers.
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            scratch_reg <= SCRATCH_RESET;
        end else if (reg_wr_i && reg_addr_i == OFS_SCRATCH) begin
            scratch_reg <= reg_wdata_i;
        end
    end

    // Bits above the select field are reserved and never stored.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            control_reg <= CONTROL_RESET;
        end else if (reg_wr_i && reg_addr_i == OFS_CONTROL) begin
            control_reg <= {2'h0, reg_wdata_i[CTL_SEL_HI:0]};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            offset_reg <= OFFSET_RESET;
        end else if (offset_wr) begin
            offset_reg <= reg_wdata_i;
        end else if ((data_wr || data_rd) && window_offset_autoinc) begin
            offset_reg <= offset_reg + OFFSET_STEP;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            self_test_reg <= SELF_TEST_RESET;
        end else if (reg_wr_i && reg_addr_i == OFS_SELF_TEST) begin
            self_test_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= READ_ZERO;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_SCRATCH: reg_rdata_o <= scratch_reg;
                OFS_CONTROL: reg_rdata_o <= control_reg;
                OFS_OFFSET: reg_rdata_o <= offset_reg;
                OFS_DATA: reg_rdata_o <= window_read(window_target_select,
                                                     window_rdata_i);
                OFS_SELF_TEST: reg_rdata_o <= self_test_reg;
                default: reg_rdata_o <= READ_ZERO;
            endcase
        end else begin
            reg_rdata_o <= READ_ZERO;
        end
    end

    // ************************************************************
    // Indirect window towards the internal blocks.
    // ************************************************************
    // Prefetch strobe fires one cycle late so it sees the updated offset.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prefetch_reg <= 1'b0;
        end else begin
            prefetch_reg <= (offset_wr && window_prefetch_enable)
                || (data_rd && window_prefetch_enable && window_offset_autoinc);
        end
    end

    // The write strobe is immediate so the write uses the offset before any auto-increment.
    always_comb begin
        window_req_o.offset = offset_reg;
        window_req_o.wdata = reg_wdata_i;
        window_req_o.wr = data_wr ? target_mask(window_target_select, 1'b1) : '0;
        window_req_o.rd = prefetch_reg ? target_mask(window_target_select, 1'b0) : '0;
    end

    // ************************************************************
    // Self-test control.
    // ************************************************************
    assign active_next = self_test_pin_control ? self_test_pin_i
                                               : self_test_reg[ST_EN_BIT];

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            toggle_reg <= 1'b0;
        end else if (!active_reg) begin
            toggle_reg <= 1'b0;
        end else if (self_test_output_mode[MODE_DATA_BIT]) begin
            toggle_reg <= self_test_data_i;
        end else if (self_test_output_mode == MODE_ALTERNATE) begin
            toggle_reg <= ~toggle_reg;
        end else begin
            toggle_reg <= 1'b0;
        end
    end

    assign self_test_active_o = active_reg;
    assign self_test_out_o = toggle_reg;
    // Clock select 3 is not blocked here; the host keeps clear of it.
    assign start_remote = active_next && !active_reg;

    iabr_remote_writer u_remote_writer (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .start_i(start_remote),
        .clock_select_i(self_test_clock_select),
        .ack_i(remote_ack_i),
        .req_o(remote_req_o),
        .payload_o(remote_payload_o)
    );

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    scratch_store_a: assert property (
        reg_wr_i && reg_addr_i == OFS_SCRATCH ##1 reg_rd_i && reg_addr_i == OFS_SCRATCH
        |-> ##1 reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("scratch read differs from last write");

    target_decode_a: assert property (
        data_wr && window_target_select == TGT_SHARED
        |-> window_req_o.wr == 4'h8)
        else $error("shared target not strobed alone");

    both_ports_a: assert property (
        data_wr && window_target_select == TGT_BOTH_PORTS
        |-> window_req_o.wr[BLK_PORT0] && window_req_o.wr[BLK_PORT1]
            && !window_req_o.wr[BLK_PATTERN] && !window_req_o.wr[BLK_SHARED])
        else $error("broadcast did not reach both ports");

    offset_step_a: assert property (
        (data_wr || data_rd) && !offset_wr && window_offset_autoinc
        |=> offset_reg == $past(offset_reg) + OFFSET_STEP)
        else $error("offset did not advance by one");

    offset_prefetch_a: assert property (
        offset_wr && window_prefetch_enable && window_target_select == TGT_PORT1
        && !(reg_wr_i && reg_addr_i == OFS_CONTROL)
        |=> window_req_o.rd == 4'h4 && window_req_o.offset == $past(reg_wdata_i))
        else $error("prefetch strobe missing after offset write");

    read_prefetch_a: assert property (
        data_rd && window_prefetch_enable && window_offset_autoinc
        |=> prefetch_reg ##0 window_req_o.offset == $past(offset_reg) + OFFSET_STEP)
        else $error("prefetch strobe missing after data read");

    window_write_a: assert property (
        data_wr |-> window_req_o.wdata == reg_wdata_i && window_req_o.offset == offset_reg)
        else $error("window write carries wrong byte or offset");

    window_read_a: assert property (
        data_rd && window_target_select == TGT_PATTERN
        |=> reg_rdata_o == $past(window_rdata_i[BLK_PATTERN]))
        else $error("window read returned wrong byte");

    alternate_out_a: assert property (
        active_reg && self_test_output_mode == MODE_ALTERNATE
        ##1 active_reg && self_test_output_mode == MODE_ALTERNATE
        |-> self_test_out_o != $past(self_test_out_o))
        else $error("alternating output did not toggle");

    static_out_a: assert property (
        self_test_output_mode == MODE_STATIC && $past(self_test_output_mode) == MODE_STATIC
        |=> !self_test_out_o)
        else $error("static mode output moved");

    pin_source_a: assert property (
        self_test_pin_control |=> self_test_active_o == $past(self_test_pin_i))
        else $error("pin control not followed");

    remote_start_a: assert property (
        start_remote && !remote_req_o
        |=> remote_req_o && remote_payload_o.offset == REMOTE_CLOCK_OFFSET
            && remote_payload_o.clock_select == $past(self_test_clock_select))
        else $error("remote clock select write not issued");

    enable_bit_a: assert property (
        !self_test_pin_control && !self_test_reg[ST_EN_BIT] |=> !self_test_active_o)
        else $error("self-test active while disabled");

    reserved_quiet_a: assert property (
        window_target_select inside {4'h3, 4'h4, [4'h7:4'hF]} && (data_wr || data_rd)
        |-> window_req_o.wr == '0 ##1 reg_rdata_o == READ_ZERO && window_req_o.rd == '0)
        else $error("reserved target touched or read non-zero");

    offset_load_a: assert property (
        offset_wr |=> offset_reg == $past(reg_wdata_i))
        else $error("offset write not stored");

    offset_hold_a: assert property (
        (data_wr || data_rd) && !window_offset_autoinc
        |=> offset_reg == $past(offset_reg))
        else $error("offset moved without auto-increment");

    select_store_a: assert property (
        reg_wr_i && reg_addr_i == OFS_CONTROL
        |=> window_target_select == $past(reg_wdata_i[CTL_SEL_HI:CTL_SEL_LO]))
        else $error("target select not stored");

    prefetch_off_a: assert property (
        offset_wr && !window_prefetch_enable |=> window_req_o.rd == '0)
        else $error("read strobe without prefetch enable");

    write_only_a: assert property (
        !data_wr |-> window_req_o.wr == '0)
        else $error("block write strobe without data write");

    shared_read_a: assert property (
        data_rd && window_target_select == TGT_SHARED
        |=> reg_rdata_o == $past(window_rdata_i[BLK_SHARED]))
        else $error("shared block read returned wrong byte");

    data_mode_a: assert property (
        active_reg && self_test_output_mode[MODE_DATA_BIT]
        |=> self_test_out_o == $past(self_test_data_i))
        else $error("data mode output does not follow data");

    reg_enable_a: assert property (
        !self_test_pin_control && self_test_reg[ST_EN_BIT] |=> self_test_active_o)
        else $error("self-test not active while enabled");

    remote_hold_a: assert property (
        remote_req_o && !remote_ack_i |=> remote_req_o && $stable(remote_payload_o))
        else $error("remote request dropped before acknowledge");

endmodule

// file: rtl/iabr_remote_writer.sv
`timescale 1ns/1ps
module iabr_remote_writer (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    input wire logic [1:0] clock_select_i,
    input wire logic ack_i,
    output logic req_o,
    output iabr_pkg::iabr_remote_write_type payload_o
);
    import iabr_pkg::*;

    iabr_remote_state_type state_reg;

    // ************************************************************
    // Request holds until the control channel acknowledges it.
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg <= RW_IDLE;
        end else begin
            case (state_reg)
                RW_IDLE: begin
                    if (start_i) begin
                        state_reg <= RW_BUSY;
                    end
                end
                RW_BUSY: begin
                    if (ack_i) begin
                        state_reg <= RW_IDLE;
                    end
                end
                default: begin
                    state_reg <= RW_IDLE;
                end
            endcase
        end
    end

    // A start seen while busy is dropped; enable edges that close are rare.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            payload_o <= '0;
        end else if (start_i && state_reg == RW_IDLE) begin
            payload_o.offset <= REMOTE_CLOCK_OFFSET;
            payload_o.clock_select <= clock_select_i;
        end
    end

    assign req_o = (state_reg == RW_BUSY);

endmodule

// file: tb/iabr_block_model.sv
`timescale 1ns/1ps
module iabr_block_model (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire iabr_pkg::iabr_window_req_type window_req_i,
    output logic [iabr_pkg::NUM_BLOCKS-1:0][7:0] window_rdata_o,
    input wire logic remote_req_i,
    output logic remote_ack_o = 1'b0
);
    import iabr_pkg::*;
    logic [7:0] mem [NUM_BLOCKS][256];
    logic [1:0] wait_reg = 2'h0;

    // ************************************************************
    // Register blocks behind the window.
    // ************************************************************
    // Each byte of a block starts distinct, so a stray write shows up.
    initial begin
        for (int b = 0; b < NUM_BLOCKS; b++) begin
            for (int a = 0; a < 256; a++) begin
                mem[b][a] = 8'(b * 64 + a);
            end
        end
    end
    always @(posedge core_clk_i) begin
        for (int b = 0; b < NUM_BLOCKS; b++) begin
            if (window_req_i.wr[b]) begin
                mem[b][window_req_i.offset] <= window_req_i.wdata;
            end
        end
    end
    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_rd
        assign window_rdata_o[b] = mem[b][window_req_i.offset];
    end

    // ************************************************************
    // Control channel answers the remote write slowly.
    // ************************************************************
    always @(posedge core_clk_i) begin
        if (srst_i || !remote_req_i || remote_ack_o) begin
            wait_reg <= 2'h0;
            remote_ack_o <= 1'b0;
        end else if (wait_reg == 2'h3) begin
            remote_ack_o <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// file: tb/indirect_access_bist_regs_tb_top.sv
`timescale 1ns/1ps
module indirect_access_bist_regs_tb_top;
    import iabr_pkg::*;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic self_test_pin_i = 1'b0;
    logic self_test_data_i = 1'b0;
    logic [7:0] reg_rdata_o;
    iabr_window_req_type window_req_o;
    logic [NUM_BLOCKS-1:0][7:0] window_rdata_i;
    logic self_test_active_o;
    logic self_test_out_o;
    logic remote_req_o;
    iabr_remote_write_type remote_payload_o;
    logic remote_ack_i;
    int bad_count = 0;
    int check_count = 0;
    int wr_count = 0;
    int rd_count = 0;
    int rem_count = 0;
    int n;
    logic [3:0] rd_mask = 4'h0;
    iabr_remote_write_type rem_seen;
    logic prev;
    logic [3:0] good [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
    logic [3:0] resv [3] = '{4'h3, 4'h4, 4'h7};

    always #5 core_clk_i = ~core_clk_i;

    iabr_regs i_iabr_regs (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .window_req_o(window_req_o),
        .window_rdata_i(window_rdata_i), .self_test_pin_i(self_test_pin_i),
        .self_test_data_i(self_test_data_i), .self_test_active_o(self_test_active_o),
        .self_test_out_o(self_test_out_o), .remote_req_o(remote_req_o),
        .remote_payload_o(remote_payload_o), .remote_ack_i(remote_ack_i)
    );
    iabr_block_model i_iabr_block_model (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .window_req_i(window_req_o),
        .window_rdata_o(window_rdata_i), .remote_req_i(remote_req_o),
        .remote_ack_o(remote_ack_i)
    );

    // ************************************************************
    // Monitors, checks and bus tasks.
    // ************************************************************
    always @(posedge core_clk_i) begin
        if (window_req_o.wr != 4'h0) wr_count++;
        if (window_req_o.rd != 4'h0) begin
            rd_count++;
            rd_mask = window_req_o.rd;
        end
        if (remote_req_o && remote_ack_i) begin
            rem_count++;
            rem_seen = remote_payload_o;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk_i);
        reg_addr_i <= addr;
        reg_wdata_i <= data;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string msg);
        @(posedge core_clk_i);
        reg_addr_i <= addr;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(reg_rdata_o, exp, msg);
    endtask
    task automatic settle(input int cycles);
        repeat (cycles) @(posedge core_clk_i);
        #1;
    endtask
    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hang must still end in a verdict.
    initial begin
        repeat (5000) @(posedge core_clk_i);
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        finish_test();
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        repeat (3) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd_chk(OFS_SCRATCH, 8'h01, "scratch reset");
        rd_chk(OFS_CONTROL, 8'h00, "control reset");
        rd_chk(OFS_OFFSET, 8'h00, "offset reset");
        rd_chk(OFS_SELF_TEST, 8'h08, "self-test reset");
        rd_chk(8'h7A, 8'h00, "unmapped read");
        wr(OFS_SCRATCH, 8'hA5);
        rd_chk(OFS_SCRATCH, 8'hA5, "scratch store");
        // Write and read with no gap, as the bus allows.
        @(posedge core_clk_i);
        reg_addr_i <= OFS_SCRATCH;
        reg_wdata_i <= 8'h3C;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(reg_rdata_o, 8'h3C, "scratch back to back");
        wr(OFS_CONTROL, 8'hFF);
        rd_chk(OFS_CONTROL, 8'h3F, "control top bits");
        $display("Test reset and storage done");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CONTROL, {2'h0, good[i], 2'h0});
            wr(OFS_OFFSET, 8'(8'h40 + i));
            wr(OFS_DATA, 8'(8'h10 + i));
            check(i_iabr_block_model.mem[i][8'(8'h40 + i)], 8'(8'h10 + i), "write");
            check(i_iabr_block_model.mem[(i + 1) % 4][8'(8'h40 + i)],
                8'(((i + 1) % 4) * 64 + 8'h40 + i), "stray write");
            rd_chk(OFS_DATA, 8'(8'h10 + i), "window read");
        end
        wr(OFS_CONTROL, 8'h18);
        wr(OFS_OFFSET, 8'h55);
        wr(OFS_DATA, 8'h9A);
        check(i_iabr_block_model.mem[1][8'h55], 8'h9A, "both ports 0");
        check(i_iabr_block_model.mem[2][8'h55], 8'h9A, "both ports 1");
        check(i_iabr_block_model.mem[3][8'h55], 8'h15, "both ports stray");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CONTROL, {2'h0, resv[i], 2'h0});
            n = wr_count;
            wr(OFS_OFFSET, 8'h60);
            wr(OFS_DATA, 8'hEE);
            check(8'(wr_count - n), 8'h00, "reserved write");
            rd_chk(OFS_DATA, 8'h00, "reserved read");
        end
        $display("Test targets done");
        wr(OFS_CONTROL, 8'h06);
        wr(OFS_OFFSET, 8'hFE);
        wr(OFS_DATA, 8'h11);
        wr(OFS_DATA, 8'h22);
        rd_chk(OFS_OFFSET, 8'h00, "offset wrap");
        check(i_iabr_block_model.mem[1][8'hFF], 8'h22, "second write");
        rd_chk(OFS_DATA, 8'h40, "autoinc read");
        rd_chk(OFS_OFFSET, 8'h01, "offset after read");
        $display("Test auto-increment done");
        wr(OFS_CONTROL, 8'h09);
        n = rd_count;
        wr(OFS_OFFSET, 8'h30);
        settle(2);
        check(8'(rd_count - n), 8'h01, "prefetch on offset");
        check({4'h0, rd_mask}, 8'h04, "prefetch target");
        rd_chk(OFS_DATA, 8'hB0, "read no autoinc");
        settle(2);
        check(8'(rd_count - n), 8'h01, "no prefetch after read");
        wr(OFS_CONTROL, 8'h0B);
        rd_chk(OFS_DATA, 8'hB0, "read with autoinc");
        settle(2);
        check(8'(rd_count - n), 8'h02, "prefetch after read");
        $display("Test prefetch done");
        // The host never picks clock select 3 here.
        n = rem_count;
        wr(OFS_SELF_TEST, 8'h45);
        rd_chk(OFS_SELF_TEST, 8'h45, "self-test readback");
        settle(12);
        check(8'(rem_count - n), 8'h01, "remote write");
        check(rem_seen.offset, 8'h14, "remote offset");
        check({6'h0, rem_seen.clock_select}, 8'h02, "remote select");
        check({7'h0, self_test_active_o}, 8'h01, "enabled");
        prev = self_test_out_o;
        settle(1);
        check({7'h0, self_test_out_o}, {7'h0, ~prev}, "alternating");
        wr(OFS_SELF_TEST, 8'h85);
        @(posedge core_clk_i);
        self_test_data_i <= 1'b1;
        settle(3);
        check({7'h0, self_test_out_o}, 8'h01, "data mode high");
        @(posedge core_clk_i);
        self_test_data_i <= 1'b0;
        settle(3);
        check({7'h0, self_test_out_o}, 8'h00, "data mode low");
        wr(OFS_SELF_TEST, 8'h05);
        settle(3);
        check({7'h0, self_test_out_o}, 8'h00, "static mode");
        wr(OFS_SELF_TEST, 8'h04);
        settle(3);
        check({7'h0, self_test_active_o}, 8'h00, "disabled");
        wr(OFS_SELF_TEST, 8'h09);
        settle(3);
        check({7'h0, self_test_active_o}, 8'h00, "pin low wins");
        n = rem_count;
        @(posedge core_clk_i);
        self_test_pin_i <= 1'b1;
        settle(12);
        check({7'h0, self_test_active_o}, 8'h01, "pin high");
        check(8'(rem_count - n), 8'h01, "pin remote write");
        @(posedge core_clk_i);
        self_test_pin_i <= 1'b0;
        settle(3);
        check({7'h0, self_test_active_o}, 8'h00, "pin released");
        $display("Test self-test done");
        finish_test();
    end
endmodule
